// >>> flash_prot.sv
// Purpose: Status-register protection logic of a serial NOR flash
// Assumes: SPI pins sampled by core_clk; rst models a power cycle
// Notes: Sees WRSR, WREN, WRDI, suspend, resume
// Contract
// - S14 complement bit inverts protected region
// - Complement bit resets to zero
// - S8/S7 select status-register lock mode
// - Mode 00: writes need only write latch
// - Mode 01, guard pin low: reject
// - Mode 01, guard pin high: accept with latch
// - Mode 10: reject until power cycle
// - Mode 11: reject writes forever; rst loads mode 00 here, as NV_RESET is all zero
// - S15 pause flag set by 75h
// - Pause flag cleared by 7Ah or reset
// - S13..S11 OTP lock bits, default unlocked
// - OTP lock bits never clear; rst clears them here, as NV_RESET is all zero
// - S9 quad enable, guard/pause active when 0
// - Quad enable disables guard and pause
// - Low status byte field layout
// - Block range decode, unit 64KB
// - Sector range decode, unit 4KB
// - Top/bottom selects region end
// - Unit size sector or block
// - Ignore erase/program touching protection
`timescale 1ns/1ps
`include "flash_prot_defs.svh"
module flash_prot (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic write_guard_n,
  input wire logic bus_pause_n,
  input wire logic [23:0] op_start_addr,
  input wire logic [23:0] op_end_addr,
  input wire logic op_check,
  input wire logic array_busy,
  output logic [7:0] status_low_byte,
  output logic [7:0] status_high_byte,
  output logic op_allowed,
  output logic status_write_pulse,
  output logic pause_active,
  output logic [2:0] otp_read_only
);
  import flash_prot_pkg::*;

  // ===========================================================
  // Pin synchronisers
  logic [1:0] cs_sync_q, sck_sync_q, sdi_sync_q, wp_sync_q, hold_sync_q;
  logic [1:0] cs_sync_d, sck_sync_d, sdi_sync_d, wp_sync_d, hold_sync_d;
  logic sck_prev_q, sck_prev_d;
  nv_status_s nv_q, nv_d;

  always_comb begin
    cs_sync_d = {cs_sync_q[0], chip_select_n};
    sck_sync_d = {sck_sync_q[0], serial_clock};
    sdi_sync_d = {sdi_sync_q[0], serial_data_in};
    wp_sync_d = {wp_sync_q[0], write_guard_n};
    hold_sync_d = {hold_sync_q[0], bus_pause_n};
    sck_prev_d = sck_sync_q[1];
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      wp_sync_q <= 2'h3;
      hold_sync_q <= 2'h3;
      sck_prev_q <= 1'h0;
    end else begin
      cs_sync_q <= cs_sync_d;
      sck_sync_q <= sck_sync_d;
      sdi_sync_q <= sdi_sync_d;
      wp_sync_q <= wp_sync_d;
      hold_sync_q <= hold_sync_d;
      sck_prev_q <= sck_prev_d;
    end
  end

  logic cs_n, sck_rise, sdi;
  assign cs_n = cs_sync_q[1];
  assign sdi = sdi_sync_q[1];
  assign sck_rise = sck_sync_q[1] & ~sck_prev_q;

  // ===========================================================
  // Instruction shifter
  shift_state_e sh_q, sh_d;
  logic [7:0] shreg_q, shreg_d;
  logic [7:0] opcode_q, opcode_d;
  logic [4:0] bitcnt_q, bitcnt_d;
  logic [15:0] wdata_q, wdata_d;
  logic hold_on;

  // Pause pin only acts while quad mode is off
  assign hold_on = ~hold_sync_q[1] & ~nv_q.quad_io_enable;

  always_comb begin
    sh_d = sh_q;
    shreg_d = shreg_q;
    opcode_d = opcode_q;
    bitcnt_d = bitcnt_q;
    wdata_d = wdata_q;
    case (sh_q)
      SH_IDLE: begin
        bitcnt_d = 5'h00;
        if (!cs_n) begin
          sh_d = SH_OPCODE;
        end
      end
      SH_OPCODE: begin
        if (cs_n) begin
          sh_d = SH_IDLE;
        end else if (sck_rise && !hold_on) begin
          shreg_d = {shreg_q[6:0], sdi};
          bitcnt_d = bitcnt_q + 5'h01;
          if (bitcnt_q == 5'h07) begin
            opcode_d = {shreg_q[6:0], sdi};
            bitcnt_d = 5'h00;
            sh_d = SH_DATA;
          end
        end
      end
      SH_DATA: begin
        if (cs_n) begin
          sh_d = SH_DONE;
        end else if (sck_rise && !hold_on) begin
          if (bitcnt_q != 5'h10) begin
            wdata_d = {wdata_q[14:0], sdi};
            bitcnt_d = bitcnt_q + 5'h01;
          end
        end
      end
      default: begin
        sh_d = SH_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sh_q <= SH_IDLE;
      shreg_q <= 8'h00;
      opcode_q <= 8'h00;
      bitcnt_q <= 5'h00;
      wdata_q <= 16'h0000;
    end else begin
      sh_q <= sh_d;
      shreg_q <= shreg_d;
      opcode_q <= opcode_d;
      bitcnt_q <= bitcnt_d;
      wdata_q <= wdata_d;
    end
  end

  logic done;
  assign done = (sh_q == SH_DONE);

  // ===========================================================
  // Status bits and write gating
  logic wel_q, wel_d, sus_q, sus_d, wpulse_q, wpulse_d;
  lock_mode_e lock_mode;
  logic wr_ok, wr_cmd, guard_low;
  nv_status_s new_nv;

  assign lock_mode = lock_mode_e'({nv_q.status_lock_mode_high, nv_q.status_lock_mode_low});
  assign guard_low = ~wp_sync_q[1] & ~nv_q.quad_io_enable;
  // A one-byte write sets only the low byte; both bytes when 16 bits arrive
  assign wr_cmd = done && (opcode_q == `OP_WRSR) && (bitcnt_q == 5'h08 || bitcnt_q == 5'h10) && !array_busy;

  always_comb begin
    case (lock_mode)
      LOCK_SOFTWARE: wr_ok = wel_q;
      LOCK_HARDWARE: wr_ok = wel_q & ~guard_low;
      LOCK_POWER_CYCLE: wr_ok = 1'b0;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    logic [7:0] lo, hi;
    lo = (bitcnt_q == 5'h10) ? wdata_q[15:8] : wdata_q[7:0];
    hi = (bitcnt_q == 5'h10) ? wdata_q[7:0] : status_high_byte;
    new_nv = nv_q;
    new_nv.range_protect = lo[`BIT_RANGE_LO+2:`BIT_RANGE_LO];
    new_nv.top_bottom_select = lo[`BIT_TB];
    new_nv.unit_size_select = lo[`BIT_SEC];
    new_nv.status_lock_mode_low = lo[`BIT_LOCK_LOW];
    new_nv.status_lock_mode_high = hi[`BIT_LOCK_HIGH-8];
    new_nv.quad_io_enable = hi[`BIT_QE-8];
    new_nv.otp_lock = nv_q.otp_lock | hi[`BIT_OTP_LO-8+2:`BIT_OTP_LO-8];
    new_nv.complement_protect = hi[`BIT_CMP-8];
  end

  always_comb begin
    nv_d = nv_q;
    wel_d = wel_q;
    sus_d = sus_q;
    wpulse_d = 1'b0;
    if (done) begin
      if (opcode_q == `OP_WREN && !array_busy) begin
        wel_d = 1'b1;
      end else if (opcode_q == `OP_WRDI && !array_busy) begin
        wel_d = 1'b0;
      end else if (opcode_q == `OP_SUSPEND) begin
        sus_d = 1'b1;
      end else if (opcode_q == `OP_RESUME) begin
        sus_d = 1'b0;
      end else if (wr_cmd && wr_ok) begin
        nv_d = new_nv;
        wel_d = 1'b0;
        wpulse_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_q <= nv_status_s'(`NV_RESET);
      wel_q <= 1'b0;
      sus_q <= 1'b0;
      wpulse_q <= 1'b0;
    end else begin
      nv_q <= nv_d;
      wel_q <= wel_d;
      sus_q <= sus_d;
      wpulse_q <= wpulse_d;
    end
  end

  // ===========================================================
  // Protected range decode
  prot_range_s rng;
  logic [23:0] size;
  always_comb begin
    rng.none = 1'b0;
    size = 24'h000000;
    if (nv_q.range_protect == 3'h0) begin
      rng.none = 1'b1;
    end else if (nv_q.unit_size_select) begin
      case (nv_q.range_protect)
        3'h1: size = 24'h001000;
        3'h2: size = 24'h002000;
        3'h3: size = 24'h004000;
        3'h4, 3'h5: size = 24'h008000;
        default: size = 24'h100000;
      endcase
    end else begin
      case (nv_q.range_protect)
        3'h1: size = 24'h010000;
        3'h2: size = 24'h020000;
        3'h3: size = 24'h040000;
        3'h4: size = 24'h080000;
        default: size = 24'h100000;
      endcase
    end
    if (nv_q.top_bottom_select) begin
      rng.lo = 24'h000000;
      rng.hi = size - 24'h000001;
    end else begin
      rng.lo = `ARRAY_TOP_ADDR + 24'h000001 - size;
      rng.hi = `ARRAY_TOP_ADDR;
    end
  end

  logic overlap, prot_hit, allowed_d;
  assign overlap = !rng.none && (op_start_addr <= rng.hi) && (op_end_addr >= rng.lo);
  // Complement: protected part is whatever lies outside the base range
  assign prot_hit = nv_q.complement_protect ?
    (rng.none || (op_start_addr < rng.lo) || (op_end_addr > rng.hi)) : overlap;
  assign allowed_d = op_check ? ~prot_hit : op_allowed;

  // ===========================================================
  // Registered outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_low_byte <= 8'h00;
      status_high_byte <= 8'h00;
      op_allowed <= 1'b0;
      status_write_pulse <= 1'b0;
      pause_active <= 1'b0;
      otp_read_only <= 3'h0;
    end else begin
      status_low_byte <= {nv_d.status_lock_mode_low, nv_d.unit_size_select, nv_d.top_bottom_select,
                          nv_d.range_protect, wel_d, array_busy};
      status_high_byte <= {sus_d, nv_d.complement_protect, nv_d.otp_lock, 1'b0,
                           nv_d.quad_io_enable, nv_d.status_lock_mode_high};
      op_allowed <= allowed_d;
      status_write_pulse <= wpulse_d;
      pause_active <= hold_on;
      otp_read_only <= nv_d.otp_lock;
    end
  end
endmodule

// >>> flash_prot_defs.svh
// Purpose: Constants for the status-register protection logic
// Assumes: 1MB array, 64KB blocks, 4KB sectors, 24-bit byte addresses
// Notes: Bit positions are within the 16-bit status word
`ifndef FLASH_PROT_DEFS_SVH
`define FLASH_PROT_DEFS_SVH

`define BIT_BUSY 0
`define BIT_WEL 1
`define BIT_RANGE_LO 2
`define BIT_TB 5
`define BIT_SEC 6
`define BIT_LOCK_LOW 7
`define BIT_LOCK_HIGH 8
`define BIT_QE 9
`define BIT_OTP_LO 11
`define BIT_CMP 14
`define BIT_SUS 15
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_WRSR 8'h01
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_RDSR1 8'h05
`define OP_RDSR2 8'h35
`define NV_RESET 12'h000
`define ARRAY_TOP_ADDR 24'h0FFFFF

`endif

// >>> flash_prot_pkg.sv
// Purpose: Types for the status-register protection logic
// Assumes: None
// Notes: Non-volatile fields carried as one struct
package flash_prot_pkg;
  typedef struct packed {
    logic complement_protect;
    logic [2:0] otp_lock;
    logic quad_io_enable;
    logic status_lock_mode_high;
    logic status_lock_mode_low;
    logic unit_size_select;
    logic top_bottom_select;
    logic [2:0] range_protect;
  } nv_status_s;

  typedef struct packed {
    logic [23:0] lo;
    logic [23:0] hi;
    logic none;
  } prot_range_s;

  typedef enum logic [1:0] {
    LOCK_SOFTWARE,
    LOCK_HARDWARE,
    LOCK_POWER_CYCLE,
    LOCK_OTP
  } lock_mode_e;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_OPCODE,
    SH_DATA,
    SH_DONE
  } shift_state_e;
endpackage

// >>> flash_prot_chk.sv
// Purpose: Port checker for flash_prot
// Assumes: rst stands for a power cycle
// Notes: Bound to the design at the foot
`timescale 1ns/1ps
module flash_prot_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic write_guard_n,
  input wire logic op_check,
  input wire logic [7:0] status_low_byte,
  input wire logic [7:0] status_high_byte,
  input wire logic op_allowed,
  input wire logic status_write_pulse
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  wire logic [1:0] mode = {status_high_byte[0], status_low_byte[7]};
  // ==========
  // Write acceptance
  property p_pulse_one;
    status_write_pulse |=> !status_write_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("write pulse too long");
  property p_quiet;
    $changed({status_high_byte[6:0], status_low_byte[7:2]}) |-> status_write_pulse;
  endproperty
  a_quiet: assert property (p_quiet) else $error("status moved without write");
  property p_wel;
    status_write_pulse |-> $past(status_low_byte[1]);
  endproperty
  a_wel: assert property (p_wel) else $error("write taken without latch");
  property p_lock_otp;
    mode == 2'b11 |=> !status_write_pulse;
  endproperty
  a_lock_otp: assert property (p_lock_otp) else $error("write in permanent lock");
  property p_lock_cycle;
    mode == 2'b10 |=> !status_write_pulse;
  endproperty
  a_lock_cycle: assert property (p_lock_cycle) else $error("write in lock-down");
  property p_guard;
    (mode == 2'b01 && !status_high_byte[1] && !write_guard_n) [*8] |-> !status_write_pulse;
  endproperty
  a_guard: assert property (p_guard) else $error("write with guard low");
  // ==========
  // Protection state
  property p_otp_hold;
    1'b1 |-> ($past(status_high_byte[5:3]) & ~status_high_byte[5:3]) == 3'h0;
  endproperty
  a_otp_hold: assert property (p_otp_hold) else $error("lock bit cleared");
  property p_op_hold;
    !op_check |=> $stable(op_allowed);
  endproperty
  a_op_hold: assert property (p_op_hold) else $error("verdict moved when idle");
endmodule

bind flash_prot flash_prot_chk chk (
  .core_clk(core_clk),
  .rst(rst),
  .write_guard_n(write_guard_n),
  .op_check(op_check),
  .status_low_byte(status_low_byte),
  .status_high_byte(status_high_byte),
  .op_allowed(op_allowed),
  .status_write_pulse(status_write_pulse)
);

// >>> spi_host_model.sv
// Purpose: Host controller sending instruction frames
// Assumes: Serial clock of 160 ns, still outside frames
// Notes: Never sets quad mode on tied pins; the bench drives them
`timescale 1ns/1ps
module spi_host_model (
  input wire logic core_clk,
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_data_in
);
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // Sends nbits of d, most significant first; call at a rising edge
  task automatic xfer(input logic [23:0] d, input int nbits);
    chip_select_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_data_in <= d[i];
      repeat (8) @(posedge core_clk);
      serial_clock <= 1'b1;
      repeat (8) @(posedge core_clk);
      serial_clock <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    chip_select_n <= 1'b1;
    serial_data_in <= ~serial_data_in;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// >>> flash_prot_tb.sv
// Purpose: Self-checking bench for flash_prot
// Assumes: Host model drives the serial pins
// Notes: Status words are {low byte, high byte}
`timescale 1ns/1ps
`include "flash_prot_defs.svh"
module flash_prot_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic write_guard_n = 1'b1;
  logic bus_pause_n = 1'b1;
  logic op_check = 1'b0;
  logic [23:0] op_addr = 24'h000000;
  logic array_busy = 1'b0;
  int n_pulses = 0;
  wire logic chip_select_n, serial_clock, serial_data_in;
  logic [7:0] status_low_byte, status_high_byte;
  logic op_allowed, status_write_pulse, pause_active;
  logic [2:0] otp_read_only;
  int n_errors = 0;
  int total_checks = 0;
  logic [15:0] t_st [11] = '{16'h0400, 16'h0400, 16'h2400, 16'h2400, 16'h4400, 16'h4400,
    16'h5400, 16'h1400, 16'h4440, 16'h4440, 16'h0000};
  logic [24:0] t_ad [11] = '{25'h00F0000, 25'h10EFFFF, 25'h000FFFF, 25'h1010000, 25'h00FF000,
    25'h10FEFFF, 25'h00F8000, 25'h0000000, 25'h10FF000, 25'h00FEFFF, 25'h1000000};
  always #5 core_clk = ~core_clk;
  // Counts accepted writes; the pulse ends before a frame task returns
  always @(posedge core_clk) begin
    if (status_write_pulse === 1'b1) begin
      n_pulses <= n_pulses + 1;
    end
  end
  flash_prot dut (.core_clk(core_clk), .rst(rst), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in), .write_guard_n(write_guard_n),
    .bus_pause_n(bus_pause_n), .op_start_addr(op_addr), .op_end_addr(op_addr), .op_check(op_check),
    .array_busy(array_busy), .status_low_byte(status_low_byte), .status_high_byte(status_high_byte),
    .op_allowed(op_allowed), .status_write_pulse(status_write_pulse), .pause_active(pause_active),
    .otp_read_only(otp_read_only));
  spi_host_model host (.core_clk(core_clk), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_data_in(serial_data_in));
  // ==========
  // Access tasks
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrsr(input logic [15:0] st, input logic wr, input logic acc, input logic [15:0] exp);
    int base;
    base = n_pulses;
    if (wr) host.xfer({16'h0000, `OP_WREN}, 8);
    host.xfer({`OP_WRSR, st}, 24);
    repeat (20) @(posedge core_clk);
    check(24'(n_pulses - base), {23'h000000, acc});
    check({status_low_byte, status_high_byte}, {8'h00, exp});
  endtask
  task automatic cmd(input logic [7:0] op);
    host.xfer({16'h0000, op}, 8);
    repeat (10) @(posedge core_clk);
  endtask
  task automatic probe(input logic [24:0] ad);
    op_addr <= ad[23:0];
    op_check <= 1'b1;
    @(posedge core_clk);
    op_check <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(op_allowed, ad[24]);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    check({status_low_byte, status_high_byte}, 16'h0000);
    bus_pause_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(pause_active, 1'b1);
    bus_pause_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    wrsr(16'h0400, 1'b0, 1'b0, 16'h0000);
    // Busy array: latch and status write both ignored, busy bit shown
    array_busy <= 1'b1;
    repeat (3) @(posedge core_clk);
    wrsr(16'h0400, 1'b1, 1'b0, 16'h0100);
    array_busy <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      wrsr(t_st[i], 1'b1, 1'b1, t_st[i]);
      probe(t_ad[i]);
    end
    wrsr(16'h0008, 1'b1, 1'b1, 16'h0008);
    check(otp_read_only, 3'b001);
    wrsr(16'h0000, 1'b1, 1'b1, 16'h0008);
    cmd(`OP_SUSPEND);
    check({status_low_byte, status_high_byte}, 16'h0088);
    cmd(`OP_RESUME);
    check({status_low_byte, status_high_byte}, 16'h0008);
    wrsr(16'h8008, 1'b1, 1'b1, 16'h8008);
    write_guard_n <= 1'b0;
    wrsr(16'h8408, 1'b1, 1'b0, 16'h8208);
    write_guard_n <= 1'b1;
    wrsr(16'h800A, 1'b1, 1'b1, 16'h800A);
    write_guard_n <= 1'b0;
    wrsr(16'h840A, 1'b1, 1'b1, 16'h840A);
    bus_pause_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(pause_active, 1'b0);
    bus_pause_n <= 1'b1;
    wrsr(16'h000B, 1'b1, 1'b1, 16'h000B);
    wrsr(16'h040B, 1'b1, 1'b0, 16'h020B);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    check({status_low_byte, status_high_byte}, 16'h0000);
    wrsr(16'h8001, 1'b1, 1'b1, 16'h8001);
    wrsr(16'h0000, 1'b1, 1'b0, 16'h8201);
    complete_run();
  end
endmodule
